// File: logic/breakpoint_lookup_table.sv
`timescale 1ns/1ps
// Contract
// R01: Eleven points of X, Y and response give up to ten segments.
// R02: Control input is the selector plus instance pair.
// R03: With auto reload, a new source or its limits reloads defaults.
// R04: A change of axis interpretation reloads defaults.
// R05: Axis defaults to value driven; elapsed time is the alternative.
// R06: Value defaults put X1 at input minimum, X10 at maximum.
// R07: Point 0 defaults to 0,0; X0 takes minimum when it is negative.
// R08: Used X values non-decreasing and within input floor and ceiling.
// R09: Input floor and ceiling follow the selected source's limits.
// R10: Truncated points drop out of the X ordering check.
// R11: Y values take any value with no ordering.
// R12: Output floor and ceiling are lowest and highest used Y.
// R13: Truncated Y values are left out of the output limits.
// R14: Configurer edits X from point 10 downward.
// R15: Configurer selects the input before writing points.
// R16: Interpolating segment blends linearly between bounding Y values.
// R17: Step segment outputs point N's Y between X(N-1) and X(N).
// R18: Truncation above point 0 drops it and higher; above gives last Y.
// R19: After reset no input is selected and the table is disabled.
// R20: Input below X0 gives Y0; output follows input and table.
module breakpoint_lookup_table
#(
   parameter int unsigned MS_CYCLES = lut_pkg::MS_CYCLES_DFLT
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Configuration
   input wire logic [lut_pkg::SELW-1:0] control_input_selector,
   input wire logic [lut_pkg::SELW-1:0] control_input_instance,
   input wire lut_pkg::axis_t axis_interpretation,
   input wire logic auto_default_reload,
   // Point write
   input wire logic pt_wr_en,
   input wire logic [lut_pkg::IDXW-1:0] pt_wr_index,
   input wire lut_pkg::pt_field_t pt_wr_field,
   input wire lut_pkg::word_t pt_wr_data,
   // Point readback
   input wire logic [lut_pkg::IDXW-1:0] pt_rd_index,
   output lut_pkg::word_t pt_rd_x,
   output lut_pkg::word_t pt_rd_y,
   output lut_pkg::seg_resp_t pt_rd_resp,
   // Upstream control source
   input wire lut_pkg::word_t control_value,
   input wire lut_pkg::word_t source_min,
   input wire lut_pkg::word_t source_max,
   // Results and status
   output lut_pkg::word_t table_out,
   output lut_pkg::word_t output_floor,
   output lut_pkg::word_t output_ceiling,
   output lut_pkg::word_t input_floor,
   output lut_pkg::word_t input_ceiling,
   output logic table_enabled,
   output logic x_order_ok,
   output logic wr_refused
);
   import lut_pkg::*;

   typedef struct packed
   {
      word_arr_t x;
      word_arr_t y;
      resp_arr_t resp;
      logic [SELW-1:0] sel;
      logic [SELW-1:0] inst;
      logic en;
      word_t lim_lo;
      word_t lim_hi;
      axis_t axis;
      word_t out;
      word_t out_lo;
      word_t out_hi;
      logic order_ok;
      logic refused;
      ctl_state_t ctl;
      logic [31:0] tick;
      word_t elapsed;
      word_t rd_x;
      word_t rd_y;
      seg_resp_t rd_resp;
   } state_t;

   localparam state_t ST_RST = '{
      x: '0, y: '0, resp: '0, sel: SRC_NONE, inst: '0, en: 1'b0,
      lim_lo: WORD_RST, lim_hi: WORD_RST, axis: value_driven_response,
      out: WORD_RST, out_lo: WORD_RST, out_hi: WORD_RST, order_ok: 1'b1,
      refused: 1'b0, ctl: ctl_off, tick: MS_CNT_RST, elapsed: WORD_RST,
      rd_x: WORD_RST, rd_y: WORD_RST, rd_resp: interpolate_segment};

   // First truncated index, or all eleven points
   function automatic logic [IDXW-1:0] used_count(resp_arr_t r);
      logic [IDXW-1:0] n;
      n = IDXW'(NPTS);
      for (int i = NPTS - 1; i >= 1; i--)
         if (r[i] == truncate_points)
            n = IDXW'(i);
      return n;
   endfunction
   function automatic word_arr_t default_x(axis_t a, word_t lo, word_t hi);
      word_arr_t r;
      logic signed [2*DW-1:0] span;
      r = '0;
      span = 64'(hi) - 64'(lo);
      if (a == elapsed_time_response)
         for (int i = 0; i < NPTS; i++)
            r[i] = DW'(i * DEF_T_STEP_MS);
      else
      begin
         // R07: negative minimum pulls x0 down
         r[0] = (lo < 0) ? lo : WORD_RST;
         // R06: x1 at minimum, x10 at maximum
         r[1] = lo;
         for (int i = 2; i < NPTS; i++)
            r[i] = lo + DW'((span * 64'(i - 1)) / 64'(NPTS - 2));
      end
      return r;
   endfunction
   function automatic word_arr_t default_y();
      word_arr_t r;
      for (int i = 0; i < NPTS; i++)
         r[i] = DW'(i * DEF_Y_STEP);
      return r;
   endfunction

   state_t st_ff;
   state_t nxt;
   logic [IDXW-1:0] used;
   logic src_chg;
   logic axis_chg;
   logic wr_ok;
   word_t lower;
   word_t upper;
   int wi;

   point_if pif();
   lut_eval i_lut_eval (.p(pif.eval_side));

   assign used = used_count(st_ff.resp);
   assign pif.x = st_ff.x;
   assign pif.y = st_ff.y;
   assign pif.resp = st_ff.resp;
   assign pif.used = used;
   // Time axis walks the profile by elapsed ms, not by the input value
   assign pif.in_val = (st_ff.axis == elapsed_time_response) ?
      st_ff.elapsed : control_value;

   always_comb
   begin
      nxt = st_ff;
      wi = int'(pt_wr_index);
      lower = WORD_RST;
      upper = WORD_RST;
      wr_ok = 1'b0;
      nxt.refused = 1'b0;
      // R02: source identity is selector plus instance
      src_chg = control_input_selector != st_ff.sel ||
         control_input_instance != st_ff.inst ||
         source_min != st_ff.lim_lo || source_max != st_ff.lim_hi;
      axis_chg = axis_interpretation != st_ff.axis;
      nxt.sel = control_input_selector;
      nxt.inst = control_input_instance;
      // R09: limits track the selected source
      nxt.lim_lo = source_min;
      nxt.lim_hi = source_max;
      // R05: axis mode held as configured
      nxt.axis = axis_interpretation;
      // R03: auto reload on source change; R04: always on axis change
      if (axis_chg || (auto_default_reload && src_chg))
      begin
         nxt.x = default_x(axis_interpretation, source_min, source_max);
         nxt.y = default_y();
         nxt.resp = '0;
      end
      // R01: point storage written by index
      else if (pt_wr_en && wi < NPTS)
      begin
         case (pt_wr_field)
            fld_x:
            begin
               // R08: write must keep neighbours ordered
               lower = (wi == 0) ? st_ff.lim_lo : $signed(st_ff.x[wi-1]);
               upper = (wi + 1 < int'(used)) ?
                  $signed(st_ff.x[wi+1]) : st_ff.lim_hi;
               // R10: truncated points accept any X
               wr_ok = wi >= int'(used) ||
                  (pt_wr_data >= lower && pt_wr_data <= upper);
               if (wr_ok)
                  nxt.x[wi] = pt_wr_data;
               nxt.refused = !wr_ok;
            end
            // R11: Y taken unchecked
            fld_y: nxt.y[wi] = pt_wr_data;
            fld_resp:
            begin
               // R18: point 0 cannot truncate
               wr_ok = pt_wr_data[1:0] != 2'b11 &&
                  !(wi == 0 && pt_wr_data[1:0] == truncate_points);
               if (wr_ok)
                  nxt.resp[wi] = seg_resp_t'(pt_wr_data[1:0]);
               nxt.refused = !wr_ok;
            end
            default: nxt.refused = 1'b1;
         endcase
      end
      else if (pt_wr_en)
         nxt.refused = 1'b1;

      // R08: ordering status over used points; R10: truncated skipped
      nxt.order_ok = $signed(st_ff.x[0]) >= st_ff.lim_lo &&
         $signed(st_ff.x[int'(used)-1]) <= st_ff.lim_hi;
      // R12: Y span; R13: truncated Y excluded
      nxt.out_lo = $signed(st_ff.y[0]);
      nxt.out_hi = $signed(st_ff.y[0]);
      for (int i = 1; i < NPTS; i++)
         if (i < int'(used))
         begin
            if ($signed(st_ff.x[i]) < $signed(st_ff.x[i-1]))
               nxt.order_ok = 1'b0;
            if ($signed(st_ff.y[i]) < nxt.out_lo)
               nxt.out_lo = $signed(st_ff.y[i]);
            if ($signed(st_ff.y[i]) > nxt.out_hi)
               nxt.out_hi = $signed(st_ff.y[i]);
         end
      // Hysteresis keeps an analog source from chattering the timer
      case (st_ff.ctl)
         ctl_off:
            if (control_value >= st_ff.lim_hi)
               nxt.ctl = ctl_on;
         ctl_on:
            if (control_value <= st_ff.lim_lo)
               nxt.ctl = ctl_off;
         default: nxt.ctl = ctl_off;
      endcase
      // Profile restarts at x0 each time the input comes on
      if (st_ff.axis == elapsed_time_response && st_ff.ctl == ctl_on)
      begin
         if (st_ff.tick >= MS_CYCLES - 1)
         begin
            nxt.tick = MS_CNT_RST;
            if (st_ff.elapsed != ELAPSED_MAX)
               nxt.elapsed = st_ff.elapsed + 32'sd1;
         end
         else
            nxt.tick = st_ff.tick + 32'h0000_0001;
      end
      else
      begin
         nxt.tick = MS_CNT_RST;
         nxt.elapsed = WORD_RST;
      end
      // R19: no selection means no output; R20: recomputed every cycle
      nxt.en = control_input_selector != SRC_NONE;
      if (st_ff.sel == SRC_NONE ||
         (st_ff.axis == elapsed_time_response && st_ff.ctl == ctl_off))
         nxt.out = WORD_RST;
      else
         nxt.out = pif.res;
      nxt.rd_x = WORD_RST;
      nxt.rd_y = WORD_RST;
      nxt.rd_resp = interpolate_segment;
      if (int'(pt_rd_index) < NPTS)
      begin
         nxt.rd_x = st_ff.x[pt_rd_index];
         nxt.rd_y = st_ff.y[pt_rd_index];
         nxt.rd_resp = st_ff.resp[pt_rd_index];
      end
   end

   // R19: reset leaves no input selected
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         st_ff <= ST_RST;
      else
         st_ff <= nxt;

   assign table_out = st_ff.out;
   assign output_floor = st_ff.out_lo;
   assign output_ceiling = st_ff.out_hi;
   assign input_floor = st_ff.lim_lo;
   assign input_ceiling = st_ff.lim_hi;
   assign table_enabled = st_ff.en;
   assign x_order_ok = st_ff.order_ok;
   assign wr_refused = st_ff.refused;
   assign pt_rd_x = st_ff.rd_x;
   assign pt_rd_y = st_ff.rd_y;
   assign pt_rd_resp = st_ff.rd_resp;
endmodule

// File: logic/lut_eval.sv
`timescale 1ns/1ps
module lut_eval
(
   // Table contents and query
   point_if.eval_side p
);
   import lut_pkg::*;

   logic signed [2*DW-1:0] prod;
   logic signed [2*DW-1:0] dx;
   word_t res;

   always_comb
   begin
      // R20: below x0 gives y0
      res = $signed(p.y[0]);
      prod = '0;
      dx = '0;
      for (int k = 1; k < NPTS; k++)
      begin
         // R18: truncated points never reached
         if (k < int'(p.used) && $signed(p.in_val) > $signed(p.x[k-1]))
         begin
            // R17: step holds y[k] over segment
            if ($signed(p.in_val) >= $signed(p.x[k]) ||
               p.resp[k] == step_segment)
            begin
               res = $signed(p.y[k]);
            end
            else
            begin
               // R16: linear blend of bounding points
               prod = (64'($signed(p.y[k])) - 64'($signed(p.y[k-1]))) *
                  (64'($signed(p.in_val)) - 64'($signed(p.x[k-1])));
               dx = 64'($signed(p.x[k])) - 64'($signed(p.x[k-1]));
               res = $signed(p.y[k-1]) + DW'(prod / dx);
            end
         end
      end
   end

   assign p.res = res;
endmodule

// File: shared/lut_pkg.sv
package lut_pkg;
   localparam int DW = 32;
   localparam int NPTS = 11;
   localparam int NSEGS = 10;
   localparam int SELW = 8;
   localparam int IDXW = 4;

   typedef logic signed [DW-1:0] word_t;
   typedef word_t [NPTS-1:0] word_arr_t;

   typedef enum logic [1:0]
   {
      interpolate_segment = 2'b00,
      step_segment = 2'b01,
      truncate_points = 2'b10
   } seg_resp_t;
   typedef seg_resp_t [NPTS-1:0] resp_arr_t;

   typedef enum logic
   {
      value_driven_response = 1'b0,
      elapsed_time_response = 1'b1
   } axis_t;

   typedef enum logic [1:0]
   {
      fld_x = 2'b00,
      fld_y = 2'b01,
      fld_resp = 2'b10
   } pt_field_t;

   typedef enum logic
   {
      ctl_off = 1'b0,
      ctl_on = 1'b1
   } ctl_state_t;

   // Selector value meaning no control input
   localparam logic [SELW-1:0] SRC_NONE = 8'h00;

   // Default Y spacing in percent per point, default time step in ms
   localparam int DEF_Y_STEP = 10;
   localparam int DEF_T_STEP_MS = 1000;

   // Elapsed-time unit and its cycle count at the core clock
   localparam int TIME_UNIT_NS = 1000000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_CYCLES_DFLT = TIME_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [31:0] MS_CNT_RST = 32'h0000_0000;
   localparam logic [DW-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [DW-1:0] ELAPSED_MAX = 32'h7fff_ffff;
endpackage

// File: shared/point_if.sv
`timescale 1ns/1ps
interface point_if;
   import lut_pkg::*;
   word_arr_t x;
   word_arr_t y;
   resp_arr_t resp;
   logic [IDXW-1:0] used;
   word_t in_val;
   word_t res;
   modport table_side (output x, output y, output resp, output used,
      output in_val, input res);
   modport eval_side (input x, input y, input resp, input used,
      input in_val, output res);
endinterface

// File: verification/breakpoint_lookup_table_tb_top.sv
`timescale 1ns/1ps
module breakpoint_lookup_table_tb_top;
   import lut_pkg::*;
   logic core_clk;
   logic resetn = 0;
   logic [SELW-1:0] control_input_selector = 8'h0;
   logic [SELW-1:0] control_input_instance = 8'h0;
   axis_t axis_interpretation = value_driven_response;
   logic auto_default_reload = 1;
   logic pt_wr_en = 0;
   logic [IDXW-1:0] pt_wr_index = 4'h0;
   logic [IDXW-1:0] pt_rd_index = 4'h0;
   pt_field_t pt_wr_field = fld_x;
   word_t pt_wr_data = 32'h0;
   word_t req_val = 32'h0;
   word_t req_min = 32'h0;
   word_t req_max = 32'h0;
   word_t control_value, source_min, source_max, pt_rd_x, pt_rd_y;
   word_t table_out, output_floor, output_ceiling;
   word_t input_floor, input_ceiling, lo, hi;
   seg_resp_t pt_rd_resp;
   logic table_enabled, x_order_ok, wr_refused;
   word_arr_t ex, ey;
   resp_arr_t er;
   int miscompares = 0;
   int num_checks = 0;
   int seed = 32'h1511e782;

   ctl_source i_ctl_source (.core_clk, .req_val, .req_min, .req_max,
      .control_value, .source_min, .source_max);
   breakpoint_lookup_table #(.MS_CYCLES(4)) i_breakpoint_lookup_table (
      .core_clk, .resetn, .control_input_selector, .control_input_instance,
      .axis_interpretation, .auto_default_reload, .pt_wr_en, .pt_wr_index,
      .pt_wr_field, .pt_wr_data, .pt_rd_index, .pt_rd_x, .pt_rd_y,
      .pt_rd_resp, .control_value, .source_min, .source_max, .table_out,
      .output_floor, .output_ceiling, .input_floor, .input_ceiling,
      .table_enabled, .x_order_ok, .wr_refused);

   initial
   begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(string nm, word_t seen, word_t exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic settle;
      repeat (4) @(negedge core_clk);
   endtask

   task automatic set_defaults;
      for (int i = 0; i < NPTS; i++)
      begin
         ey[i] = DEF_Y_STEP * i;
         er[i] = interpolate_segment;
         if (axis_interpretation == elapsed_time_response)
            ex[i] = DEF_T_STEP_MS * i;
         else if (i == 0)
            ex[i] = (req_min < 0) ? req_min : 32'h0;
         else
            ex[i] = req_min + (longint'(req_max) - req_min) * (i - 1) / 9;
      end
   endtask

   function automatic word_t eval(word_t v);
      int n;
      longint d;
      n = NPTS;
      for (int i = NSEGS; i >= 1; i--)
         if (er[i] === truncate_points)
            n = i;
      if (v <= ex[0])
         return ey[0];
      for (int k = 1; k < n; k++)
      begin
         if (v == ex[k])
            return ey[k];
         if (v < ex[k])
         begin
            if (er[k] === step_segment)
               return ey[k];
            d = longint'(ey[k]) - ey[k-1];
            return word_t'(ey[k-1] + d * (v - ex[k-1]) / (ex[k] - ex[k-1]));
         end
      end
      return ey[n-1];
   endfunction

   task automatic wr(int i, pt_field_t f, word_t d, logic bad);
      @(negedge core_clk);
      pt_wr_en = 1;
      pt_wr_index = 4'(i);
      pt_wr_field = f;
      pt_wr_data = d;
      @(negedge core_clk);
      pt_wr_en = 0;
      check("wr_refused", wr_refused, bad);
      if (!bad)
         case (f)
            fld_x: ex[i] = d;
            fld_y: ey[i] = d;
            default: er[i] = seg_resp_t'(d[1:0]);
         endcase
   endtask

   task automatic cmp_pts;
      for (int i = 0; i < NPTS; i++)
      begin
         @(negedge core_clk);
         pt_rd_index = 4'(i);
         repeat (2) @(negedge core_clk);
         check("pt_rd_x", pt_rd_x, ex[i]);
         check("pt_rd_y", pt_rd_y, ey[i]);
         check("pt_rd_resp", pt_rd_resp, er[i]);
      end
   endtask

   task automatic probe(word_t v);
      @(negedge core_clk);
      req_val <= v;
      settle;
      check("table_out", table_out, eval(v));
   endtask

   initial
   begin
      #400000;
      miscompares++;
      close_out;
   end

   initial
   begin
      repeat (10) @(negedge core_clk);
      resetn = 1;
      check("table_enabled", table_enabled, 0);
      check("table_out", table_out, 0);
      check("x_order_ok", x_order_ok, 1);
      req_min <= 32'h0;
      req_max <= 32'd100;
      control_input_selector = 8'h05;
      control_input_instance = 8'h02;
      settle;
      set_defaults;
      cmp_pts;
      check("table_enabled", table_enabled, 1);
      check("input_ceiling", input_ceiling, 100);
      check("output_ceiling", output_ceiling, 100);
      probe(0);
      probe(100);
      repeat (16) probe($random(seed) % 140);
      wr(10, fld_x, 95, 0);
      wr(9, fld_x, 96, 1);
      wr(0, fld_x, -1, 1);
      wr(11, fld_y, 0, 1);
      wr(2, pt_field_t'(2'h3), 0, 1);
      wr(3, fld_resp, 3, 1);
      wr(0, fld_resp, 2, 1);
      wr(3, fld_resp, 1, 0);
      for (int i = 0; i < NPTS; i++)
         wr(i, fld_y, $random(seed) % 500, 0);
      wr(6, fld_resp, 2, 0);
      wr(8, fld_x, 5, 0);
      settle;
      lo = ey[0];
      hi = ey[0];
      for (int i = 1; i < 6; i++)
      begin
         if (ey[i] < lo)
            lo = ey[i];
         if (ey[i] > hi)
            hi = ey[i];
      end
      check("output_floor", output_floor, lo);
      check("output_ceiling", output_ceiling, hi);
      check("x_order_ok", x_order_ok, 1);
      probe(500);
      repeat (16) probe($random(seed) % 100);
      cmp_pts;
      // Negative minimum pulls point zero down
      req_min <= -40;
      req_max <= 210;
      settle;
      set_defaults;
      cmp_pts;
      auto_default_reload = 0;
      req_max <= 300;
      req_min <= -30;
      settle;
      check("input_ceiling", input_ceiling, 300);
      check("input_floor", input_floor, -30);
      check("x_order_ok", x_order_ok, 0);
      cmp_pts;
      axis_interpretation = elapsed_time_response;
      req_val <= -50;
      settle;
      set_defaults;
      cmp_pts;
      // Time profile: zero while off, starts at point zero when on
      wr(0, fld_y, 77, 0);
      settle;
      check("table_out", table_out, 0);
      @(negedge core_clk);
      req_val <= 400;
      settle;
      check("table_out", table_out, eval(0));
      axis_interpretation = value_driven_response;
      settle;
      set_defaults;
      cmp_pts;
      check("x_order_ok", x_order_ok, 1);
      control_input_selector = SRC_NONE;
      settle;
      check("table_enabled", table_enabled, 0);
      check("table_out", table_out, 0);
      close_out;
   end
endmodule

bind breakpoint_lookup_table lut_monitor i_lut_monitor (.core_clk, .resetn,
   .control_input_selector, .pt_wr_en, .pt_wr_index, .pt_wr_field,
   .pt_wr_data, .source_min, .table_out, .output_floor, .output_ceiling,
   .input_floor, .table_enabled, .wr_refused);

// File: verification/ctl_source.sv
`timescale 1ns/1ps
module ctl_source
(
   // Clock
   input wire logic core_clk,
   // Requests from the bench
   input wire lut_pkg::word_t req_val,
   input wire lut_pkg::word_t req_min,
   input wire lut_pkg::word_t req_max,
   // Source outputs
   output lut_pkg::word_t control_value,
   output lut_pkg::word_t source_min,
   output lut_pkg::word_t source_max
);
   import lut_pkg::*;
   always @(negedge core_clk)
   begin
      control_value <= req_val;
      source_min <= req_min;
      source_max <= req_max;
   end
endmodule

// File: verification/lut_monitor.sv
`timescale 1ns/1ps
module lut_monitor
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Stimulus side
   input wire logic [lut_pkg::SELW-1:0] control_input_selector,
   input wire logic pt_wr_en,
   input wire logic [lut_pkg::IDXW-1:0] pt_wr_index,
   input wire lut_pkg::pt_field_t pt_wr_field,
   input wire lut_pkg::word_t pt_wr_data,
   input wire lut_pkg::word_t source_min,
   // Results
   input wire lut_pkg::word_t table_out,
   input wire lut_pkg::word_t output_floor,
   input wire lut_pkg::word_t output_ceiling,
   input wire lut_pkg::word_t input_floor,
   input wire logic table_enabled,
   input wire logic wr_refused
);
   import lut_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_bad_index;
      pt_wr_en && pt_wr_index > 4'ha;
   endsequence
   sequence s_bad_field;
      pt_wr_en && pt_wr_index <= 4'ha && pt_wr_field == 2'h3;
   endsequence
   sequence s_trunc_zero;
      pt_wr_en && pt_wr_index == 4'h0 && pt_wr_field == fld_resp
         && pt_wr_data[1:0] == 2'h2;
   endsequence
   sequence s_x0_low;
      pt_wr_en && pt_wr_index == 4'h0 && pt_wr_field == fld_x
         && pt_wr_data < input_floor;
   endsequence
   a_bad_index: assert property (s_bad_index |=> wr_refused)
      else $error("index above ten not refused");
   a_bad_field: assert property (s_bad_field |=> wr_refused)
      else $error("unknown field not refused");
   a_trunc_zero: assert property (s_trunc_zero |=> wr_refused)
      else $error("truncate at point zero not refused");
   a_x_below_floor: assert property (s_x0_low |=> wr_refused)
      else $error("X0 below floor not refused");
   a_refuse_cause: assert property (wr_refused |-> $past(pt_wr_en))
      else $error("refusal without a write");
   a_enable_sel: assert property (table_enabled ==
      ($past(control_input_selector) != SRC_NONE))
      else $error("enable does not follow selector");
   a_floor_src: assert property (input_floor == $past(source_min))
      else $error("input floor does not follow source");
   a_out_limits: assert property (output_floor <= output_ceiling)
      else $error("output floor above ceiling");
   a_off_zero: assert property (!table_enabled
      && control_input_selector == SRC_NONE |=> table_out == 32'h0)
      else $error("disabled table drives nonzero");
endmodule
